// ---- design/avtb_pkg.sv ----
// Purpose: Shared constants, types and helpers for the axis velocity / time breakpoint block
// Assumes: 100 MHz clock, four axes, 32-bit classic Wishbone register bus
// Notes:   Breakpoint outputs sit on I/O bits 5..8, one per axis
package avtb_pkg;
  // ***************************************************
  // Timing
  // ***************************************************
  localparam int unsigned CLK_HZ = 100_000_000;
  localparam int unsigned CLK_NS = 1_000_000_000 / CLK_HZ;
  localparam int unsigned SAMPLE_NS = 341_000;
  localparam int unsigned TICK_CYC = SAMPLE_NS / CLK_NS;

  // ***************************************************
  // Geometry and limits
  // ***************************************************
  localparam int NUM_AX = 4;
  localparam int IO_W = 9;
  localparam int BRK_BIT0 = 5;
  localparam int VEL_FRAC = 16;
  localparam logic [15:0] ANT_MIN = 16'h0001;
  localparam logic [15:0] ANT_MAX = 16'hffff;
  localparam logic [15:0] ANT_RST = 16'h0001;
  localparam logic [31:0] VEL_SRV_MAX = 32'h00ff_ffff;
  localparam logic [31:0] VEL_SRV_RST = 32'h0000_8000;
  localparam logic [31:0] VEL_STP_MIN = 32'h0000_0001;
  localparam logic [31:0] VEL_STP_MAX = 32'h000f_ffff;
  localparam logic [31:0] VEL_STP_RST = 32'h0000_0003;

  // ***************************************************
  // Register map
  // ***************************************************
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_CFG = 8'h04;
  localparam logic [7:0] OFS_IO_DIR = 8'h08;
  localparam logic [7:0] OFS_IO_OUT = 8'h0c;
  localparam logic [7:0] OFS_IRQ_STAT = 8'h10;
  localparam logic [7:0] OFS_IRQ_CLR = 8'h14;
  localparam logic [7:0] OFS_IRQ_EN = 8'h18;
  localparam logic [7:0] OFS_STATE = 8'h1c;
  localparam logic [7:0] OFS_AXIS0 = 8'h20;
  localparam logic [7:0] OFS_AXEND = 8'h60;
  localparam logic [3:0] AX_VEL = 4'h0;
  localparam logic [3:0] AX_VACT = 4'h4;
  localparam logic [3:0] AX_ANT = 4'h8;
  localparam logic [3:0] AX_PBRK = 4'hc;
  localparam int CTL_START = 0;
  localparam int CTL_STOP = 4;
  localparam int CTL_ARM = 8;
  localparam int CTL_DIRTY = 12;
  localparam int CFG_STEP = 0;
  localparam int CFG_VMODE = 4;

  typedef enum logic [1:0] {
    AX_IDLE = 2'b00,
    AX_CALC = 2'b01,
    AX_RUN = 2'b11
  } avtb_ax_state_t;

  typedef struct packed {
    logic signed [31:0] pos;
    logic signed [31:0] end_pos;
    logic [31:0] vel;
    logic calc_done;
  } avtb_traj_t;

  typedef struct packed {
    logic [31:0] vel;
    logic go;
    logic halt;
    logic calc_req;
    logic vel_mode;
    logic stepper;
  } avtb_cmd_t;

  // ***************************************************
  // Helpers
  // ***************************************************
  function automatic logic [31:0] wmask(input logic [31:0] o, input logic [31:0] n,
                                        input logic [3:0] s);
    logic [31:0] r;
    r = o;
    for (int i = 0; i < 4; i++) begin
      if (s[i]) r[8*i +: 8] = n[8*i +: 8];
    end
    return r;
  endfunction

  function automatic logic [31:0] clamp_vel(input logic [31:0] v, input logic stp);
    if (stp) begin
      if (v < VEL_STP_MIN) return VEL_STP_MIN;
      if (v > VEL_STP_MAX) return VEL_STP_MAX;
      return v;
    end
    return (v > VEL_SRV_MAX) ? VEL_SRV_MAX : v;
  endfunction

  function automatic logic [15:0] clamp_ant(input logic [31:0] v);
    if (v[15:0] == 16'h0000 && v[31:16] == 16'h0000) return ANT_MIN;
    if (v[31:16] != 16'h0000) return ANT_MAX;
    return v[15:0];
  endfunction

  // Counts covered in t periods at 8.16 fixed-point velocity v
  function automatic logic [31:0] ant_dist(input logic [31:0] v, input logic [15:0] t);
    logic [47:0] p;
    p = {16'h0000, v} * {32'h0000_0000, t};
    return p[47:VEL_FRAC];
  endfunction

  function automatic logic [32:0] rem_dist(input logic signed [31:0] e,
                                           input logic signed [31:0] p);
    logic signed [32:0] d;
    d = 33'(e) - 33'(p);
    return d[32] ? 33'(-d) : 33'(d);
  endfunction
endpackage

// ---- design/avtb_tick.sv ----
// Purpose: Sample-period tick divider
// Assumes: Single clock; CYCLES at least 2
// Notes:   tick_o is a one-cycle enable pulse
`timescale 1ns/1ps
`default_nettype none
module avtb_tick #(
  parameter int unsigned CYCLES = 34100
) (
  input wire logic clk_i,
  input wire logic rst_i,
  output logic tick_o
);
  localparam int CW = $clog2(CYCLES);
  localparam logic [CW-1:0] LAST = CW'(CYCLES - 1);
  logic [CW-1:0] cnt_q;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cnt_q <= '0;
    end else if (cnt_q == LAST) begin
      cnt_q <= '0;
    end else begin
      cnt_q <= cnt_q + CW'(1);
    end
  end

  assign tick_o = (cnt_q == LAST);
endmodule // avtb_tick
`default_nettype wire

// ---- design/avtb_brk.sv ----
// Purpose: Shared per-axis breakpoint comparator, time or position source
// Assumes: Trajectory position and velocity valid on each tick
// Notes:   Fires once per arming
`timescale 1ns/1ps
`default_nettype none
module avtb_brk
  import avtb_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic tick_i,
  input wire logic arm_i,
  input wire logic run_i,
  input wire logic use_time_i,
  input wire logic vel_mode_i,
  input wire logic [15:0] ant_time_i,
  input wire logic signed [31:0] brk_pos_i,
  input wire avtb_traj_t traj_i,
  output logic armed_o,
  output logic fire_o
);
  logic armed_q;
  logic hit;
  logic [32:0] rem;

  assign rem = rem_dist(traj_i.end_pos, traj_i.pos); // see R8
  always_comb begin
    if (use_time_i) begin
      // Constant-velocity projection; exact only within the host velocity limits
      hit = run_i && !vel_mode_i
            && ({1'b0, ant_dist(traj_i.vel, ant_time_i)} >= rem); // see R4
    end else begin
      hit = (traj_i.pos == brk_pos_i);
    end
  end

  assign fire_o = armed_q & tick_i & hit; // see R19

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      armed_q <= 1'b0;
    end else if (arm_i) begin
      armed_q <= 1'b1;
    end else if (fire_o) begin
      armed_q <= 1'b0; // see R19
    end
  end

  assign armed_o = armed_q;
endmodule // avtb_brk
`default_nettype wire

// ---- design/avtb_axis_brk_top.sv ----
// Purpose: Four-axis velocity buffer, start/stop sequencing and time breakpoint
// Assumes: Trajectory generator outside supplies position, end and velocity
// Notes:   Registers on classic Wishbone; one level interrupt
// Behaviour
// (R1) Anticipation time is held in sample periods, 1 to 65535.
// (R2) Out-of-range loads clamp silently to the nearest limit.
// (R3) Axis n breakpoint drives its own I/O bit, 5 through 8.
// (R4) Anticipation periods convert to a position before move end.
// (R5) Reaching that position makes a transition on the axis output bit.
// (R6) Each breakpoint toggles the bit; host presets it for a chosen edge.
// (R7) Time and position breakpoints share a comparator; last loaded wins.
// (R8) Time breakpoint works in position mode only, against move end.
// (R9) Host sets bit as output, loads move, time, arms, then starts.
// (R10) Anticipation time is kept across moves; host re-arms and restarts.
// (R11) Host keeps velocity and acceleration inside the accuracy limits.
// (R12) Servo velocity is 0 to 16777215 counts per period, default 0x8000.
// (R13) Stepper velocity is 1 to 1048575 steps per second, default 3; code never loads 3, a switch to stepper re-clamps the buffer (0x8000 after reset).
// (R14) Servo velocity is fixed point with 16 fractional bits.
// (R15) In position mode the velocity is the profile peak.
// (R16) Velocity mode holds the start velocity until a new start or stop.
// (R17) Loaded velocity waits in a buffer until start or stop.
// (R18) Parameter loads force recalculation, finished before motion begins.
// (R19) Comparator checks once per tick and disarms after firing.
`timescale 1ns/1ps
`default_nettype none
module avtb_axis_brk_top
  import avtb_pkg::*;
#(
  parameter int unsigned TICK_CYCLES = TICK_CYC
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  input wire logic wb_we_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  output logic wb_ack_o,
  input wire avtb_traj_t [NUM_AX-1:0] traj_i,
  output avtb_cmd_t [NUM_AX-1:0] cmd_o,
  input wire logic [IO_W-1:0] io_i,
  output logic [IO_W-1:0] io_o,
  output logic [IO_W-1:0] io_oe_o,
  output logic sample_tick_o,
  output logic irq_o
);
  // ***************************************************
  // Bus slave
  // ***************************************************
  logic req;
  logic wr;
  logic ack_q;
  logic [31:0] dat_q;
  logic [31:0] rd_data;
  logic ax_hit;
  logic [7:0] ax_off;
  logic [1:0] ax_sel;
  logic [3:0] ax_reg;

  assign req = wb_cyc_i & wb_stb_i;
  // Write lands on the edge that the master sees ack
  assign wr = req & wb_we_i & ack_q;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_q <= 1'b0;
    end else begin
      ack_q <= req & !ack_q;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      dat_q <= '0;
    end else if (req & !ack_q) begin
      dat_q <= rd_data;
    end
  end

  assign wb_ack_o = ack_q;
  assign wb_dat_o = dat_q;

  assign ax_hit = (wb_adr_i >= OFS_AXIS0) && (wb_adr_i < OFS_AXEND);
  assign ax_off = wb_adr_i - OFS_AXIS0;
  assign ax_sel = ax_off[5:4];
  assign ax_reg = ax_off[3:0];

  logic wr_ctrl;
  logic wr_cfg;
  logic wr_dir;
  logic wr_io;
  logic wr_clr;
  logic wr_en;
  logic [31:0] ctl;
  logic [31:0] cfg_nx;

  assign wr_ctrl = wr && (wb_adr_i == OFS_CTRL);
  assign wr_cfg = wr && (wb_adr_i == OFS_CFG);
  assign wr_dir = wr && (wb_adr_i == OFS_IO_DIR);
  assign wr_io = wr && (wb_adr_i == OFS_IO_OUT);
  assign wr_clr = wr && (wb_adr_i == OFS_IRQ_CLR);
  assign wr_en = wr && (wb_adr_i == OFS_IRQ_EN);
  // Command bits are strobes, never stored
  assign ctl = wr_ctrl ? wmask(32'h0000_0000, wb_dat_i, wb_sel_i) : 32'h0000_0000;

  logic [NUM_AX-1:0] start;
  logic [NUM_AX-1:0] stop;
  logic [NUM_AX-1:0] arm;
  logic [NUM_AX-1:0] mark;

  assign start = ctl[CTL_START +: NUM_AX];
  assign stop = ctl[CTL_STOP +: NUM_AX];
  assign arm = ctl[CTL_ARM +: NUM_AX];
  assign mark = ctl[CTL_DIRTY +: NUM_AX];

  // ***************************************************
  // Configuration and I/O port
  // ***************************************************
  logic [NUM_AX-1:0] step_q;
  logic [NUM_AX-1:0] vmode_q;
  logic [IO_W-1:0] io_dir_q;
  logic [IO_W-1:0] io_out_q;
  logic [IO_W-1:0] io_out_d;
  logic [IO_W-1:0] fire_io;
  logic [NUM_AX-1:0] fire;
  logic [NUM_AX-1:0] armed;

  assign cfg_nx = wmask({24'h00_0000, vmode_q, step_q}, wb_dat_i, wb_sel_i);

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      step_q <= '0;
      vmode_q <= '0;
    end else if (wr_cfg) begin
      step_q <= cfg_nx[CFG_STEP +: NUM_AX];
      vmode_q <= cfg_nx[CFG_VMODE +: NUM_AX];
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      io_dir_q <= '0;
    end else if (wr_dir) begin
      io_dir_q <= IO_W'(wmask({23'h0, io_dir_q}, wb_dat_i, wb_sel_i));
    end
  end

  always_comb begin
    fire_io = '0;
    for (int i = 0; i < NUM_AX; i++) begin
      fire_io[BRK_BIT0 + i] = fire[i]; // see R3
    end
  end

  // Host preset applies first, so a same-cycle breakpoint still toggles
  always_comb begin
    io_out_d = io_out_q;
    if (wr_io) begin
      io_out_d = IO_W'(wmask({23'h0, io_out_q}, wb_dat_i, wb_sel_i)); // see R6
    end
    io_out_d = io_out_d ^ fire_io; // see R5
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      io_out_q <= '0;
    end else begin
      io_out_q <= io_out_d;
    end
  end

  assign io_o = io_out_q;
  assign io_oe_o = io_dir_q;

  // ***************************************************
  // Sample tick
  // ***************************************************
  logic tick;

  avtb_tick #(
    .CYCLES(TICK_CYCLES)
  ) u_tick (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .tick_o(tick)
  );

  assign sample_tick_o = tick;

  // ***************************************************
  // Per-axis state
  // ***************************************************
  logic [31:0] vel_buf_q [NUM_AX];
  logic [31:0] vel_act_q [NUM_AX];
  logic [15:0] ant_q [NUM_AX];
  logic [31:0] pbrk_q [NUM_AX];
  logic [NUM_AX-1:0] use_time_q;
  logic [NUM_AX-1:0] dirty_q;
  logic [NUM_AX-1:0] go_q;
  logic [NUM_AX-1:0] halt_q;
  logic [NUM_AX-1:0] take;
  logic [NUM_AX-1:0] running;
  logic [NUM_AX-1:0] wr_ant;
  avtb_ax_state_t st_q [NUM_AX];

  for (genvar a = 0; a < NUM_AX; a++) begin : g_ax
    logic hit;
    logic wr_vel;
    logic wr_pbrk;
    avtb_ax_state_t st_d;

    assign hit = wr && ax_hit && (ax_sel == 2'(a));
    assign wr_vel = hit && (ax_reg == AX_VEL);
    assign wr_ant[a] = hit && (ax_reg == AX_ANT);
    assign wr_pbrk = hit && (ax_reg == AX_PBRK);

    // Holding buffer; re-clamped when the axis type changes
    always_ff @(posedge clk_i) begin
      if (rst_i) begin
        vel_buf_q[a] <= VEL_SRV_RST; // see R12
      end else if (wr_vel) begin
        vel_buf_q[a] <= clamp_vel(wmask(vel_buf_q[a], wb_dat_i, wb_sel_i),
                                  step_q[a]); // see R2 R13 R17
      end else if (wr_cfg) begin
        vel_buf_q[a] <= clamp_vel(vel_buf_q[a], cfg_nx[CFG_STEP + a]);
      end
    end

    // Never cleared by a move, so a repeat only needs re-arming
    always_ff @(posedge clk_i) begin
      if (rst_i) begin
        ant_q[a] <= ANT_RST;
      end else if (wr_ant[a]) begin
        ant_q[a] <= clamp_ant(wmask({16'h0, ant_q[a]}, wb_dat_i, wb_sel_i)); // see R1 R10
      end
    end

    always_ff @(posedge clk_i) begin
      if (rst_i) begin
        pbrk_q[a] <= '0;
        use_time_q[a] <= 1'b0;
      end else if (wr_ant[a]) begin
        use_time_q[a] <= 1'b1; // see R7
      end else if (wr_pbrk) begin
        pbrk_q[a] <= wmask(pbrk_q[a], wb_dat_i, wb_sel_i);
        use_time_q[a] <= 1'b0; // see R7
      end
    end

    // New parameters wins over the clear at calc completion
    always_ff @(posedge clk_i) begin
      if (rst_i) begin
        dirty_q[a] <= 1'b1;
      end else begin
        dirty_q[a] <= (dirty_q[a] & !(st_q[a] == AX_CALC && traj_i[a].calc_done))
                      | wr_vel | mark[a]; // see R18
      end
    end

    always_comb begin
      st_d = st_q[a];
      take[a] = 1'b0;
      if (stop[a]) begin
        st_d = AX_IDLE;
        take[a] = 1'b1; // see R17
      end else begin
        unique case (st_q[a])
          AX_CALC: begin
            if (traj_i[a].calc_done) begin
              st_d = AX_RUN;
              take[a] = 1'b1; // see R18
            end
          end
          AX_IDLE, AX_RUN: begin
            if (start[a] && dirty_q[a]) begin
              st_d = AX_CALC; // see R18
            end else if (start[a]) begin
              st_d = AX_RUN;
              take[a] = 1'b1; // see R16
            end
          end
          default: st_d = AX_IDLE;
        endcase
      end
    end

    always_ff @(posedge clk_i) begin
      if (rst_i) begin
        st_q[a] <= AX_IDLE;
        go_q[a] <= 1'b0;
        halt_q[a] <= 1'b0;
      end else begin
        st_q[a] <= st_d;
        go_q[a] <= take[a] & !stop[a];
        halt_q[a] <= stop[a];
      end
    end

    // Active velocity is the peak in position mode, the run speed otherwise
    always_ff @(posedge clk_i) begin
      if (rst_i) begin
        vel_act_q[a] <= '0;
      end else if (take[a]) begin
        vel_act_q[a] <= vel_buf_q[a]; // see R15 R16 R17
      end
    end

    assign running[a] = (st_q[a] == AX_RUN);
    assign cmd_o[a] = '{vel: vel_act_q[a], go: go_q[a], halt: halt_q[a],
                        calc_req: st_q[a] == AX_CALC, vel_mode: vmode_q[a],
                        stepper: step_q[a]}; // see R14

    avtb_brk u_brk (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .tick_i(tick),
      .arm_i(arm[a]),
      .run_i(running[a]),
      .use_time_i(use_time_q[a]),
      .vel_mode_i(vmode_q[a]),
      .ant_time_i(ant_q[a]),
      .brk_pos_i(pbrk_q[a]),
      .traj_i(traj_i[a]),
      .armed_o(armed[a]),
      .fire_o(fire[a])
    );
  end

  // ***************************************************
  // Interrupts
  // ***************************************************
  logic [2*NUM_AX-1:0] stat_q;
  logic [2*NUM_AX-1:0] en_q;
  logic [31:0] clr;

  assign clr = wr_clr ? wmask(32'h0000_0000, wb_dat_i, wb_sel_i) : 32'h0000_0000;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      stat_q <= '0;
    end else begin
      stat_q <= (stat_q & ~clr[2*NUM_AX-1:0]) | {go_q, fire};
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      en_q <= '0;
    end else if (wr_en) begin
      en_q <= (2*NUM_AX)'(wmask({24'h0, en_q}, wb_dat_i, wb_sel_i));
    end
  end

  assign irq_o = |(stat_q & en_q);

  // ***************************************************
  // Read mux
  // ***************************************************
  always_comb begin
    rd_data = '0;
    if (ax_hit) begin
      case (ax_reg)
        AX_VEL: rd_data = vel_buf_q[ax_sel];
        AX_VACT: rd_data = vel_act_q[ax_sel];
        AX_ANT: rd_data = {16'h0000, ant_q[ax_sel]};
        AX_PBRK: rd_data = pbrk_q[ax_sel];
        default: rd_data = '0;
      endcase
    end else begin
      case (wb_adr_i)
        OFS_CFG: rd_data = {24'h00_0000, vmode_q, step_q};
        OFS_IO_DIR: rd_data = {23'h0, io_dir_q};
        OFS_IO_OUT: rd_data = {7'h00, io_i, 7'h00, io_out_q};
        OFS_IRQ_STAT: rd_data = {24'h00_0000, stat_q};
        OFS_IRQ_EN: rd_data = {24'h00_0000, en_q};
        OFS_STATE: rd_data = {16'h0000, use_time_q, running, dirty_q, armed};
        default: rd_data = '0;
      endcase
    end
  end

  // ***************************************************
  // Checks
  // ***************************************************
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  a_bus_ack_pulse: assert property (req && !ack_q |=> ack_q ##1 !ack_q)
    else $error("Bus answer is not a single-cycle ack");
  a_ant_nonzero: assert property (ant_q[0] != 16'h0000) // see R1
    else $error("Anticipation time left its range");
  a_ant_clamp_hi: assert property (wr_ant[0] && wb_sel_i == 4'hf // see R2
    && wb_dat_i[31:16] != 16'h0 |=> ant_q[0] == ANT_MAX)
    else $error("Large anticipation time not clamped");
  a_vel_servo_lim: assert property (!step_q[0] |-> vel_buf_q[0] <= VEL_SRV_MAX) // see R12
    else $error("Servo velocity above limit");
  a_vel_step_lim: assert property (step_q[0] |-> vel_buf_q[0] >= VEL_STP_MIN // see R13
    && vel_buf_q[0] <= VEL_STP_MAX)
    else $error("Stepper velocity out of range");
  a_vel_held_buf: assert property (!take[0] |=> $stable(vel_act_q[0])) // see R17
    else $error("Active velocity changed without start or stop");
  a_vel_mode_keep: assert property (running[0] && vmode_q[0] && !start[0] // see R16
    && !stop[0] |=> cmd_o[0].vel == $past(cmd_o[0].vel))
    else $error("Velocity-mode speed drifted");
  a_calc_before_go: assert property (st_q[0] == AX_CALC && !traj_i[0].calc_done // see R18
    && !stop[0] |=> !go_q[0] && st_q[0] == AX_CALC)
    else $error("Motion began before recalculation");
  a_brk_toggle: assert property (fire[0] && !wr_io // see R5 R6
    |=> io_out_q[BRK_BIT0] != $past(io_out_q[BRK_BIT0]))
    else $error("Breakpoint did not toggle its bit");
  a_brk_disarm: assert property (fire[0] && !arm[0] |=> !armed[0] ##1 !fire[0]) // see R19
    else $error("Comparator stayed armed after firing");
  a_brk_on_tick: assert property (fire[0] |-> tick) // see R19
    else $error("Breakpoint fired off the sample tick");
  a_ant_pos_mode: assert property (fire[0] && use_time_q[0] |-> !vmode_q[0]) // see R8
    else $error("Time breakpoint fired in velocity mode");
  a_last_cfg_used: assert property (wr_ant[0] |=> use_time_q[0]) // see R7
    else $error("Last loaded breakpoint kind not selected");
  a_irq_sticky: assert property (fire[0] && !clr[0] |=> stat_q[0] && (en_q[0] -> irq_o))
    else $error("Breakpoint event lost from status");

  c_time_fire: cover property (use_time_q[0] && fire[0]);
  c_calc_run: cover property (st_q[0] == AX_CALC ##1 st_q[0] == AX_RUN);
  c_vel_restart: cover property (running[0] && vmode_q[0] && take[0]);
endmodule // avtb_axis_brk_top
`default_nettype wire

// ---- tb/avtb_drive_model.sv ----
// Purpose: Drive and trajectory model for the four axes
// Assumes: Constant-velocity moves, whole counts per tick
// Notes:   No ramps; calc finishes one cycle after request
`timescale 1ns/1ps
`default_nettype none
module avtb_drive_model
  import avtb_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic tick_i,
  input wire avtb_cmd_t [NUM_AX-1:0] cmd_i,
  input wire logic signed [31:0] end_i,
  output var avtb_traj_t [NUM_AX-1:0] traj_o
);
  logic [NUM_AX-1:0] run_q;
  always_ff @(posedge clk_i) begin
    for (int n = 0; n < NUM_AX; n++) begin
      traj_o[n].calc_done <= cmd_i[n].calc_req;
      traj_o[n].end_pos <= end_i;
      traj_o[n].vel <= cmd_i[n].vel;
      if (rst_i) begin
        run_q[n] <= 1'b0;
        traj_o[n].pos <= '0;
      end else if (cmd_i[n].go || cmd_i[n].halt) begin
        run_q[n] <= cmd_i[n].go;
      end else if (tick_i && run_q[n]) begin
        // Integer part only; the fraction is dropped
        if (end_i - traj_o[n].pos > $signed({16'h0000, cmd_i[n].vel[31:16]})) begin
          traj_o[n].pos <= traj_o[n].pos + $signed({16'h0000, cmd_i[n].vel[31:16]});
        end else begin
          traj_o[n].pos <= end_i;
          run_q[n] <= 1'b0;
        end
      end
    end
  end
endmodule // avtb_drive_model
`default_nettype wire

// ---- tb/avtb_axis_brk_top_test.sv ----
// Purpose: Self-checking bench for the axis breakpoint block
// Assumes: Eight-clock sample tick, loopback pins with pull-ups
// Notes:   Expectations are worked out here with integers
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin cmp_count++; if ((g) !== (e)) begin mismatches++; \
  $display("ERROR %0t: got %h want %h", $time, g, e); end end
module avtb_axis_brk_top_test;
  import avtb_pkg::*;
  logic clk_i = 1'b0, rst_i = 1'b1, we = 1'b0, cyc = 1'b0, stb = 1'b0;
  logic [7:0] adr = 8'h00;
  logic [31:0] wdat = 32'h0, rdat, rd, sv, ev;
  logic [3:0] sel = 4'hf, done;
  logic ack, tick, irq;
  logic [IO_W-1:0] io_o, io_oe, io_i;
  avtb_traj_t [NUM_AX-1:0] traj;
  avtb_cmd_t [NUM_AX-1:0] cmd;
  logic signed [31:0] end_pos = 32'sh0;
  int mismatches = 0, cmp_count = 0, cyc_n = 0, seed = 16, rem, t;
  assign io_i = (io_oe & io_o) | ~io_oe;
  avtb_axis_brk_top #(.TICK_CYCLES(8)) dut (.clk_i(clk_i), .rst_i(rst_i), .wb_adr_i(adr),
    .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_we_i(we), .wb_sel_i(sel), .wb_cyc_i(cyc),
    .wb_stb_i(stb), .wb_ack_o(ack), .traj_i(traj), .cmd_o(cmd), .io_i(io_i), .io_o(io_o),
    .io_oe_o(io_oe), .sample_tick_o(tick), .irq_o(irq));
  avtb_drive_model far (.clk_i(clk_i), .rst_i(rst_i), .tick_i(tick), .cmd_i(cmd),
    .end_i(end_pos), .traj_o(traj));
  initial begin
    forever #5 clk_i = ~clk_i;
  end
  always @(posedge clk_i) begin
    cyc_n++;
    if (cyc_n == 10000) begin
      mismatches++;
      give_verdict();
    end
  end
  task automatic give_verdict();
    $display("Comparisons %0d, mismatches %0d", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  // Called just after a rising edge; leaves one idle cycle behind
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    do @(posedge clk_i); while (ack !== 1'b1);
    rd = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    @(posedge clk_i);
  endtask
  task automatic rdc(input logic [7:0] a, input logic [31:0] e);
    wb(1'b0, a, 32'h0);
    `CHK(rd, e)
  endtask
  initial begin
    repeat (10) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    rdc(OFS_AXIS0 + AX_VEL, VEL_SRV_RST);
    rdc(OFS_AXIS0 + AX_ANT, 32'h1);
    wb(1'b1, OFS_AXIS0 + AX_ANT, 32'h0);
    rdc(OFS_AXIS0 + AX_ANT, 32'h1);
    wb(1'b1, OFS_AXIS0 + AX_ANT, 32'h1_0000);
    rdc(OFS_AXIS0 + AX_ANT, 32'hffff);
    for (t = 0; t < 6; t++) begin
      sv = 32'($random(seed)) >> 6;
      ev = (sv > 32'hff_ffff) ? 32'hff_ffff : sv;
      wb(1'b1, OFS_AXIS0 + AX_VEL, sv);
      rdc(OFS_AXIS0 + AX_VEL, ev);
    end
    wb(1'b1, OFS_CFG, 32'h2);
    wb(1'b1, OFS_AXIS0 + 8'h10 + AX_VEL, 32'h0);
    rdc(OFS_AXIS0 + 8'h10 + AX_VEL, 32'h1);
    wb(1'b1, OFS_AXIS0 + 8'h10 + AX_VEL, 32'h20_0000);
    rdc(OFS_AXIS0 + 8'h10 + AX_VEL, 32'hf_ffff);
    wb(1'b1, OFS_CFG, 32'h0);
    rdc(8'h80, 32'h0);
    for (t = 0; t < NUM_AX; t++) begin
      wb(1'b1, OFS_AXIS0 + 8'(16 * t) + AX_VEL, 32'h2_0000);
      wb(1'b1, OFS_AXIS0 + 8'(16 * t) + AX_ANT, 32'h3);
    end
    rdc(OFS_AXIS0 + AX_VACT, 32'h0);
    wb(1'b1, OFS_IO_DIR, 32'h1e0);
    wb(1'b1, OFS_IO_OUT, 32'ha0);
    wb(1'b1, OFS_IRQ_EN, 32'h1);
    // Third move runs in velocity mode and must not fire
    for (int k = 0; k < 3; k++) begin
      end_pos <= 40 * (k + 1);
      if (k == 2) wb(1'b1, OFS_CFG, 32'hf0);
      wb(1'b1, OFS_CTRL, 32'hf000);
      wb(1'b1, OFS_CTRL, 32'hf00);
      sv = 32'(io_o);
      wb(1'b1, OFS_CTRL, 32'hf);
      done = 4'h0;
      for (t = 0; t < 400 && done != 4'hf; t++) begin
        @(negedge clk_i);
        for (int n = 0; n < NUM_AX; n++) begin
          if (io_o[5 + n] !== sv[5 + n] && !done[n]) begin
            done[n] = 1'b1;
            rem = end_pos - traj[n].pos;
            `CHK(rem inside {[4:6]}, 1'b1)
          end
        end
      end
      @(posedge clk_i);
      `CHK(done, (k < 2) ? 4'hf : 4'h0)
      `CHK(io_o[8:5], (k < 2) ? ~sv[8:5] : sv[8:5])
      wb(1'b0, OFS_STATE, 32'h0);
      `CHK(rd[3:0], (k < 2) ? 4'h0 : 4'hf)
      `CHK(rd[15:12], 4'hf)
      if (k == 0) begin
        rdc(OFS_AXIS0 + AX_VACT, 32'h2_0000);
        `CHK(irq, 1'b1)
        wb(1'b1, OFS_IRQ_EN, 32'h0);
        `CHK(irq, 1'b0)
        wb(1'b1, OFS_IRQ_EN, 32'h1);
        wb(1'b1, OFS_IRQ_CLR, 32'hff);
        `CHK(irq, 1'b0)
      end
    end
    wb(1'b1, OFS_AXIS0 + AX_VEL, 32'h3_0000);
    rdc(OFS_AXIS0 + AX_VACT, 32'h2_0000);
    wb(1'b1, OFS_CTRL, 32'h10);
    rdc(OFS_AXIS0 + AX_VACT, 32'h3_0000);
    wb(1'b1, OFS_AXIS0 + 8'h30 + AX_PBRK, 32'h0);
    wb(1'b0, OFS_STATE, 32'h0);
    `CHK(rd[15:12], 4'h7)
    give_verdict();
  end
endmodule // avtb_axis_brk_top_test
`default_nettype wire
